// ---- verilog/sio_pkg.sv ----
// Constants, register map and types for the serial interface block
//
// Behaviour
// - Mode bits 11/10/01/00 select async8, async7, slave, master
// - Reset leaves the block in synchronous master mode
// - Master drives internal clock on clock pin
// - Slave shifts on external clock, ignores source select
// - Slave drives ready pin from transfer state
// - Async 7-bit with selectable parity, pins released
// - Async 8-bit with selectable parity, pins released
// - Source bits select timer, osc/93, /372, /186
// - Timer source is timer underflow divided by two
// - Reset selects oscillator divided by 186
// - Internal source divided by sixteen; slave clock undivided
// - Separate transmit and receive shift registers
// - Transmit byte serialised onto serial data output
// - Received character moved into separate readable buffer
// - Transmit enable gates shifting; clock pin needs transmit or receive enable
// - Load data, then trigger write starts shifting
// - Transmit completion raises a complete event
// - Trigger bit reads one while transmitting
// - Pins are ports until pin enable assigns them
// - Async completion with unacknowledged buffer sets overrun
// - Synchronous transfers eight bits, LSB first, half duplex
// - Sync output shifts on falling edge, holds last
package sio_pkg;

    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] REG_TXD = 8'h08;
    localparam logic [ADDR_W-1:0] REG_RXD = 8'h0C;

    // Control register fields
    localparam int CTL_PIN_EN = 0;
    localparam int CTL_MODE_LO = 1;
    localparam int CTL_MODE_HI = 2;
    localparam int CTL_SRC_LO = 3;
    localparam int CTL_SRC_HI = 4;
    localparam int CTL_PAR_EN = 5;
    localparam int CTL_PAR_ODD = 6;

    // Status register fields
    localparam int ST_TX_EN = 0;
    localparam int ST_TX_TRIG = 1;
    localparam int ST_RX_EN = 2;
    localparam int ST_RX_TRIG = 3;
    localparam int ST_OVERRUN = 4;
    localparam int ST_PAR_ERR = 5;
    localparam int ST_TX_DONE = 6;
    localparam int ST_BUF_FULL = 7;

    typedef enum logic [1:0] {
        MODE_SYNC_MASTER = 2'h0,
        MODE_SYNC_SLAVE = 2'h1,
        MODE_ASYNC7 = 2'h2,
        MODE_ASYNC8 = 2'h3
    } mode_t;

    typedef enum logic [1:0] {
        SRC_DIV186 = 2'h0,
        SRC_DIV372 = 2'h1,
        SRC_DIV93 = 2'h2,
        SRC_TIMER = 2'h3
    } clk_src_t;

    // Oscillator prescaler divisors
    localparam int DIV_W = 9;
    localparam logic [DIV_W-1:0] DIV_93 = 9'h05D;
    localparam logic [DIV_W-1:0] DIV_186 = 9'h0BA;
    localparam logic [DIV_W-1:0] DIV_372 = 9'h174;

    // Sixteen source ticks per bit; mid point used for sampling and clock half period
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [3:0] SYNC_BITS = 4'h8;
    localparam logic [3:0] ASYNC7_BITS = 4'h7;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_FRAME = 3'b010,
        RX_SYNC = 3'b100
    } rx_state_t;

endpackage

// ---- verilog/sync_async_serial_interface.sv ----
// Serial interface: sync master/slave and async 7/8-bit, APB register access
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps
module sync_async_serial_interface
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sio_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer1_underflow,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    input wire logic sclk_n_in,
    output logic sclk_n_out,
    output logic sclk_n_oe,
    output logic slave_ready_n_out,
    output logic slave_ready_oe,
    output logic tx_complete
);
    import sio_pkg::*;

    // Number of bits after the start bit: data, optional parity, stop
    function automatic logic [3:0] frame_len(input logic is8, input logic par);
        frame_len = (is8 ? SYNC_BITS : ASYNC7_BITS) + {3'h0, par} + 4'h1;
    endfunction

    // Parity over the active data bits
    function automatic logic par_calc(input logic [7:0] d, input logic is8, input logic odd);
        par_calc = ^(is8 ? d : {1'b0, d[6:0]}) ^ odd;
    endfunction

    // Configuration and status registers
    logic pin_en_r;
    logic [1:0] mode_r;
    logic [1:0] src_r;
    logic par_en_r;
    logic par_odd_r;
    logic tx_en_r;
    logic rx_en_r;
    logic [7:0] tx_data_r;
    logic tx_busy_r;
    logic tx_done_r;
    logic [10:0] tx_frame_r;
    logic [3:0] tx_left_r;
    logic serial_data_out_r;
    rx_state_t rx_state_r;
    logic [7:0] rx_shift_r;
    logic [7:0] rx_buf_r;
    logic [3:0] rx_idx_r;
    logic [3:0] rx_os_r;
    logic buf_full_r;
    logic overrun_r;
    logic par_err_r;

    // Bus decode
    logic acc;
    logic wr;
    logic hit;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_txd;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign hit = (paddr == REG_CTRL) || (paddr == REG_STAT) || (paddr == REG_TXD) || (paddr == REG_RXD);
    assign wr_ctrl = wr && (paddr == REG_CTRL);
    assign wr_stat = wr && (paddr == REG_STAT);
    assign wr_txd = wr && (paddr == REG_TXD);
    assign pready = 1'b1;
    assign pslverr = acc && !hit;

    // Mode decode
    logic is_sync;
    logic is_master;
    logic is_slave;
    logic is8;
    assign is_sync = !mode_r[1];
    assign is_master = (mode_r == MODE_SYNC_MASTER);
    assign is_slave = (mode_r == MODE_SYNC_SLAVE);
    assign is8 = (mode_r == MODE_ASYNC8);

    // Control, status enable and transmit data writes; reset gives sync master, osc/186
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_en_r <= 1'b0;
            mode_r <= MODE_SYNC_MASTER;
            src_r <= SRC_DIV186;
            par_en_r <= 1'b0;
            par_odd_r <= 1'b0;
            tx_en_r <= 1'b0;
            rx_en_r <= 1'b0;
            tx_data_r <= 8'h00;
        end
        else if (ce)
        begin
            if (wr_ctrl)
            begin
                pin_en_r <= pwdata[CTL_PIN_EN];
                mode_r <= {pwdata[CTL_MODE_HI], pwdata[CTL_MODE_LO]};
                src_r <= {pwdata[CTL_SRC_HI], pwdata[CTL_SRC_LO]};
                par_en_r <= pwdata[CTL_PAR_EN];
                par_odd_r <= pwdata[CTL_PAR_ODD];
            end
            if (wr_stat)
            begin
                tx_en_r <= pwdata[ST_TX_EN];
                rx_en_r <= pwdata[ST_RX_EN];
            end
            if (wr_txd)
                tx_data_r <= pwdata[7:0];
        end
    end

    // Pin synchronisers; first stages feed only the second stages
    logic sin_s1_r;
    logic sin_s2_r;
    logic sin_d_r;
    logic sck_s1_r;
    logic sck_s2_r;
    logic sck_d_r;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sin_s1_r <= 1'b1;
            sin_s2_r <= 1'b1;
            sin_d_r <= 1'b1;
            sck_s1_r <= 1'b1;
            sck_s2_r <= 1'b1;
            sck_d_r <= 1'b1;
        end
        else if (ce)
        begin
            sin_s1_r <= serial_data_in;
            sin_s2_r <= sin_s1_r;
            sin_d_r <= sin_s2_r;
            sck_s1_r <= sclk_n_in;
            sck_s2_r <= sck_s1_r;
            sck_d_r <= sck_s2_r;
        end
    end

    // Source clock: oscillator prescaler or timer underflow halved
    logic [DIV_W-1:0] div_cnt_r;
    logic [DIV_W-1:0] div_max;
    logic tmr_half_r;
    logic src_tick;
    always_comb
    begin
        case (src_r)
            SRC_DIV93: div_max = DIV_93 - 9'h001;
            SRC_DIV372: div_max = DIV_372 - 9'h001;
            default: div_max = DIV_186 - 9'h001;
        endcase
    end
    assign src_tick = (src_r == SRC_TIMER) ? (timer1_underflow && tmr_half_r) : (div_cnt_r >= div_max);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_cnt_r <= '0;
            tmr_half_r <= 1'b0;
        end
        else if (ce)
        begin
            div_cnt_r <= (div_cnt_r >= div_max) ? '0 : div_cnt_r + 9'h001;
            if (timer1_underflow)
                tmr_half_r <= !tmr_half_r;
        end
    end

    // Divide by sixteen: bit tick and half-bit tick for the master clock
    logic [3:0] os_cnt_r;
    logic bit_tick;
    logic half_tick;
    assign bit_tick = src_tick && (os_cnt_r == OS_LAST);
    assign half_tick = src_tick && (os_cnt_r[2:0] == OS_MID[2:0]);
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            os_cnt_r <= 4'h0;
        else if (ce && src_tick)
            os_cnt_r <= os_cnt_r + 4'h1;
    end

    // Synchronous clock: generated in master, taken from pin in slave
    logic sync_busy;
    logic sclk_r;
    logic s_fall;
    logic s_rise;
    logic [3:0] sync_cnt_r;
    logic sync_last;
    assign sync_busy = is_sync && (tx_busy_r || rx_state_r == RX_SYNC);
    // Slave edges need no divider: the master's clock is used as is
    assign s_fall = sync_busy && (is_master ? (half_tick && sclk_r) : (sck_d_r && !sck_s2_r));
    assign s_rise = sync_busy && (is_master ? (half_tick && !sclk_r) : (!sck_d_r && sck_s2_r));
    assign sync_last = s_rise && (sync_cnt_r == SYNC_BITS - 4'h1);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclk_r <= 1'b1;
            sync_cnt_r <= 4'h0;
        end
        else if (ce)
        begin
            if (!sync_busy || !is_master)
                sclk_r <= 1'b1;
            else if (half_tick)
                sclk_r <= !sclk_r;
            if (!sync_busy)
                sync_cnt_r <= 4'h0;
            else if (s_rise)
                sync_cnt_r <= sync_cnt_r + 4'h1;
        end
    end

    // Transmit start: one transfer at a time on the shared sync clock
    logic tx_start;
    logic tx_async_done;
    logic tx_end;
    assign tx_start = wr_stat && pwdata[ST_TX_TRIG] && tx_en_r && !tx_busy_r
        && (!is_sync || rx_state_r != RX_SYNC);
    assign tx_async_done = !is_sync && bit_tick && (tx_left_r == 4'h0);
    assign tx_end = tx_busy_r && (is_sync ? sync_last : tx_async_done);
    assign tx_complete = tx_end;

    // Transmit shifter, separate from the receive shifter
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_busy_r <= 1'b0;
            tx_frame_r <= '1;
            tx_left_r <= 4'h0;
            serial_data_out_r <= 1'b1;
        end
        else if (ce)
        begin
            if (tx_start)
            begin
                tx_busy_r <= 1'b1;
                if (is_sync)
                    tx_frame_r <= {3'h7, tx_data_r};
                else if (is8)
                    tx_frame_r <= {1'b1, par_en_r ? par_calc(tx_data_r, 1'b1, par_odd_r) : 1'b1,
                        tx_data_r, 1'b0};
                else
                    tx_frame_r <= {2'h3, par_en_r ? par_calc(tx_data_r, 1'b0, par_odd_r) : 1'b1,
                        tx_data_r[6:0], 1'b0};
                tx_left_r <= frame_len(is8, par_en_r) + 4'h1;
            end
            else if (tx_end || !tx_en_r)
                tx_busy_r <= 1'b0;
            else if (tx_busy_r && (is_sync ? s_fall : (bit_tick && tx_left_r != 4'h0)))
            begin
                // Sync mode holds the last bit on the pin until the next transfer
                serial_data_out_r <= tx_frame_r[0];
                tx_frame_r <= {1'b1, tx_frame_r[10:1]};
                tx_left_r <= tx_left_r - 4'h1;
            end
        end
    end

    // Transmit-complete flag: write one clears, a new completion wins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            tx_done_r <= 1'b0;
        else if (ce)
        begin
            if (tx_end)
                tx_done_r <= 1'b1;
            else if (wr_stat && pwdata[ST_TX_DONE])
                tx_done_r <= 1'b0;
        end
    end

    // Receive control
    logic rx_trig_wr;
    logic rx_sync_start;
    logic rx_async_start;
    logic rx_mid;
    logic [3:0] rx_len;
    logic rx_par_slot;
    logic rx_stop_slot;
    logic rx_done;
    logic [7:0] rx_data;
    assign rx_trig_wr = wr_stat && pwdata[ST_RX_TRIG];
    assign rx_sync_start = is_sync && rx_trig_wr && rx_en_r && rx_state_r == RX_IDLE && !tx_busy_r;
    assign rx_async_start = !is_sync && rx_en_r && rx_state_r == RX_IDLE && sin_d_r && !sin_s2_r;
    assign rx_mid = src_tick && (rx_os_r == OS_MID);
    assign rx_len = frame_len(is8, par_en_r);
    assign rx_par_slot = par_en_r && (rx_idx_r == rx_len - 4'h1);
    assign rx_stop_slot = (rx_idx_r == rx_len);
    assign rx_done = (rx_state_r == RX_SYNC) ? sync_last : (rx_state_r == RX_FRAME && rx_mid && rx_stop_slot);
    // Seven-bit data arrives in the upper bits of the right-shifting register
    assign rx_data = (rx_state_r == RX_SYNC) ? {sin_s2_r, rx_shift_r[7:1]}
        : (is8 ? rx_shift_r : {1'b0, rx_shift_r[7:1]});

    // Receive shifter and state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_state_r <= RX_IDLE;
            rx_shift_r <= 8'h00;
            rx_idx_r <= 4'h0;
            rx_os_r <= 4'h0;
        end
        else if (ce)
        begin
            case (rx_state_r)
                RX_IDLE:
                begin
                    rx_idx_r <= 4'h0;
                    rx_os_r <= 4'h0;
                    if (rx_sync_start)
                        rx_state_r <= RX_SYNC;
                    else if (rx_async_start)
                        rx_state_r <= RX_FRAME;
                end
                RX_SYNC:
                begin
                    if (!rx_en_r || sync_last)
                        rx_state_r <= RX_IDLE;
                    else if (s_rise)
                        rx_shift_r <= {sin_s2_r, rx_shift_r[7:1]};
                end
                RX_FRAME:
                begin
                    if (src_tick)
                        rx_os_r <= rx_os_r + 4'h1;
                    if (!rx_en_r || is_sync)
                        rx_state_r <= RX_IDLE;
                    else if (rx_mid)
                    begin
                        rx_idx_r <= rx_idx_r + 4'h1;
                        // A start bit gone high by its centre was a glitch
                        if ((rx_idx_r == 4'h0 && sin_s2_r) || rx_stop_slot)
                            rx_state_r <= RX_IDLE;
                        else if (rx_idx_r != 4'h0 && !rx_par_slot)
                            rx_shift_r <= {sin_s2_r, rx_shift_r[7:1]};
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // Receive buffer and error flags; new events win over software clears
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_buf_r <= 8'h00;
            buf_full_r <= 1'b0;
            overrun_r <= 1'b0;
            par_err_r <= 1'b0;
        end
        else if (ce)
        begin
            if (rx_done)
            begin
                rx_buf_r <= rx_data;
                buf_full_r <= 1'b1;
            end
            else if (rx_trig_wr)
                buf_full_r <= 1'b0;
            if (rx_done && buf_full_r && !is_sync)
                overrun_r <= 1'b1;
            else if (wr_stat && pwdata[ST_OVERRUN])
                overrun_r <= 1'b0;
            if (rx_state_r == RX_FRAME && rx_mid && rx_par_slot && (sin_s2_r != par_calc(rx_data, is8, par_odd_r)))
                par_err_r <= 1'b1;
            else if (wr_stat && pwdata[ST_PAR_ERR])
                par_err_r <= 1'b0;
        end
    end

    // Pin assignment: released to the port logic unless the interface claims them
    assign serial_data_out = serial_data_out_r;
    assign serial_data_out_oe = pin_en_r;
    assign sclk_n_out = sclk_r;
    assign sclk_n_oe = pin_en_r && is_master && (tx_en_r || rx_en_r);
    // Ready low from the start of a slave transfer until its eighth rising clock
    assign slave_ready_n_out = !(is_slave && sync_busy);
    assign slave_ready_oe = pin_en_r && is_slave;

    // Read data; unmapped addresses read zero with an error
    always_comb
    begin
        prdata = 32'h0000_0000;
        case (paddr)
            REG_CTRL:
            begin
                prdata[CTL_PIN_EN] = pin_en_r;
                prdata[CTL_MODE_HI] = mode_r[1];
                prdata[CTL_MODE_LO] = mode_r[0];
                prdata[CTL_SRC_HI] = src_r[1];
                prdata[CTL_SRC_LO] = src_r[0];
                prdata[CTL_PAR_EN] = par_en_r;
                prdata[CTL_PAR_ODD] = par_odd_r;
            end
            REG_STAT:
            begin
                prdata[ST_TX_EN] = tx_en_r;
                prdata[ST_TX_TRIG] = tx_busy_r;
                prdata[ST_RX_EN] = rx_en_r;
                prdata[ST_RX_TRIG] = (rx_state_r != RX_IDLE);
                prdata[ST_OVERRUN] = overrun_r;
                prdata[ST_PAR_ERR] = par_err_r;
                prdata[ST_TX_DONE] = tx_done_r;
                prdata[ST_BUF_FULL] = buf_full_r;
            end
            REG_TXD: prdata[7:0] = tx_data_r;
            REG_RXD: prdata[7:0] = rx_buf_r;
            default: prdata = 32'h0000_0000;
        endcase
    end

endmodule

// ---- bench/sio_props.sv ----
// Port-level assertions for the serial interface
`timescale 1ns/10ps
module sio_props
    import sio_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sio_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe,
    input wire logic sclk_n_out,
    input wire logic sclk_n_oe,
    input wire logic slave_ready_n_out,
    input wire logic tx_complete
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Decode of the four register words
    logic mapped;
    assign mapped = paddr inside {REG_CTRL, REG_STAT, REG_TXD, REG_RXD};

    // Access phase; master clock low half
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_low8;
        !sclk_n_out [*8];
    endsequence

    property p_ready;
        s_access |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_unmapped;
        s_access ##0 !mapped |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mapped;
        s_access ##0 mapped |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_pin_oe;
        $changed(serial_data_out_oe) |-> $past(psel && penable && pwrite && paddr == REG_CTRL);
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("data pin enable moved without write");
    property p_clk_oe;
        $rose(sclk_n_oe) |-> $past(psel && penable && pwrite);
    endproperty
    a_clk_oe: assert property (p_clk_oe) else $error("clock pin enabled without write");
    // Low half lasts at least eight clock cycles
    property p_clk_low;
        $fell(sclk_n_out) |-> s_low8;
    endproperty
    a_clk_low: assert property (p_clk_low) else $error("master clock low half too short");
    property p_sdo_hold;
        $rose(sclk_n_out) && sclk_n_oe |-> $stable(serial_data_out);
    endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("data moved on rising clock");
    property p_done;
        tx_complete |=> !tx_complete;
    endproperty
    a_done: assert property (p_done) else $error("transmit complete longer than one cycle");
    property p_rdy_cause;
        $fell(slave_ready_n_out) |-> $past(psel && penable && pwrite && paddr == REG_STAT);
    endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("ready asserted without trigger");
endmodule

bind sync_async_serial_interface sio_props i_props (.*);

// ---- bench/serial_peer.sv ----
// External serial device: async partner, sync slave and sync master
`timescale 1ns/10ps
module serial_peer #(
    parameter int BIT_CLK = 64
) (
    input wire logic clk,
    input wire logic serial_data_out,
    input wire logic sclk_n_out,
    output logic serial_data_in,
    output logic sclk_n_in
);
    // Both lines idle high between frames
    initial
    begin
        serial_data_in = 1'b1;
        sclk_n_in = 1'b1;
    end

    // Start bit, n bits LSB first, then stop
    task automatic send_frame(input logic [9:0] b, input int n);
        serial_data_in <= 1'b0;
        repeat (BIT_CLK) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            serial_data_in <= b[i];
            repeat (BIT_CLK) @(posedge clk);
        end
        serial_data_in <= 1'b1;
        repeat (BIT_CLK) @(posedge clk);
    endtask

    // Sample start, n bits and stop at bit centres
    task automatic get_frame(input int n, output logic [10:0] b);
        int t;
        b = '0;
        t = 0;
        while (serial_data_out === 1'b1 && t < 5000)
        begin
            @(posedge clk);
            t++;
        end
        repeat (BIT_CLK / 2) @(posedge clk);
        for (int i = 0; i <= n + 1; i++)
        begin
            b[i] = serial_data_out;
            repeat (BIT_CLK) @(posedge clk);
        end
    endtask

    // Capture eight bits on rising clock, measure the period
    task automatic sync_listen(output logic [7:0] d, output int per);
        time t0;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sclk_n_out);
            d[i] = serial_data_out;
            if (i == 0)
                t0 = $time;
            if (i == 1)
                per = int'(($time - t0) / 20);
        end
    endtask

    // Drive eight clocks, data changed on falling edge
    task automatic sync_drive(input logic [7:0] d, input int half);
        for (int i = 0; i < 8; i++)
        begin
            sclk_n_in <= 1'b0;
            serial_data_in <= d[i];
            repeat (half) @(posedge clk);
            sclk_n_in <= 1'b1;
            repeat (half) @(posedge clk);
        end
        serial_data_in <= ~d[7];
    endtask
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the serial interface
`timescale 1ns/10ps
module tb;
    import sio_pkg::*;
    logic clk, arst_n, ce, psel, penable, pwrite, tmr_uf, pready, pslverr, perr, tx_complete;
    logic serial_data_in, serial_data_out, serial_data_out_oe, sclk_n_in, sclk_n_out, sclk_n_oe;
    logic slave_ready_n_out, slave_ready_oe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int fails = 0, n_tests = 0, cyc = 0;

    sync_async_serial_interface i_sync_async_serial_interface (.*, .timer1_underflow(tmr_uf));
    // Timer pulse every second clock gives 64 clocks per bit
    serial_peer peer (.clk(clk), .serial_data_out(serial_data_out), .sclk_n_out(sclk_n_out),
        .serial_data_in(serial_data_in), .sclk_n_in(sclk_n_in));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Timer underflow pulses and hang guard
    always @(posedge clk)
    begin
        tmr_uf <= ~tmr_uf;
        cyc++;
        if (cyc == 60000)
        begin
            fails++;
            complete_run;
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] x;
        apb(1'b0, a, 32'h0, x);
        cmp(x & m, e);
    endtask

    // Pin enables and ready level
    task automatic pins(input logic [31:0] e);
        @(posedge clk);
        cmp({28'h0, serial_data_out_oe, sclk_n_oe, slave_ready_oe, slave_ready_n_out}, e);
    endtask

    task automatic wait_done;
        int t;
        t = 0;
        while (tx_complete !== 1'b1 && t < 20000)
        begin
            @(posedge clk);
            t++;
        end
        cmp({31'h0, tx_complete}, 32'h1);
    endtask

    function automatic logic [31:0] ctl(input mode_t m, input clk_src_t s, input logic [1:0] par);
        return {25'h0, par, s, m, 1'b1};
    endfunction

    task automatic t_reset;
        logic [31:0] x;
        // Write with ce low is lost
        ce <= 1'b0;
        wr(REG_CTRL, 32'h1);
        ce <= 1'b1;
        chk(REG_CTRL, 32'hFF, 32'h0);
        chk(REG_STAT, 32'hFF, 32'h0);
        pins(32'h1);
        cmp({30'h0, serial_data_out, tx_complete}, 32'h2);
        apb(1'b0, 8'h10, 32'h0, x);
        cmp({31'h0, perr}, 32'h1);
    endtask

    task automatic t_async_tx;
        logic [10:0] f;
        wr(REG_CTRL, ctl(MODE_ASYNC8, SRC_TIMER, 2'b01));
        wr(REG_TXD, 32'hA6);
        wr(REG_STAT, 32'h1);
        pins(32'h9);
        wr(REG_STAT, 32'h3);
        fork
            peer.get_frame(9, f);
            begin
                chk(REG_STAT, 32'h2, 32'h2);
                wait_done;
            end
        join
        cmp({21'h0, f}, {21'h0, 1'b1, ^8'hA6, 8'hA6, 1'b0});
        chk(REG_STAT, 32'h42, 32'h40);
        wr(REG_STAT, 32'h0);
    endtask

    task automatic t_duplex;
        logic [10:0] f;
        wr(REG_CTRL, ctl(MODE_ASYNC7, SRC_TIMER, 2'b11));
        wr(REG_TXD, 32'h35);
        wr(REG_STAT, 32'h5);
        wr(REG_STAT, 32'h7);
        fork
            peer.get_frame(8, f);
            peer.send_frame({2'b0, ~^7'h4B, 7'h4B}, 8);
        join
        cmp({21'h0, f}, {22'h0, 1'b1, ~^7'h35, 7'h35, 1'b0});
        chk(REG_RXD, 32'hFF, 32'h4B);
        chk(REG_STAT, 32'h80, 32'h80);
        fork
            peer.send_frame({2'b0, ~^7'h19, 7'h19}, 8);
            begin
                repeat (200) @(posedge clk);
                chk(REG_RXD, 32'hFF, 32'h4B);
            end
        join
        chk(REG_STAT, 32'h10, 32'h10);
        wr(REG_STAT, 32'h0);
    endtask

    // Oscillator source counts from reset, so no settle wait is modelled
    task automatic t_sync_master;
        logic [7:0] d;
        int per;
        wr(REG_CTRL, ctl(MODE_SYNC_MASTER, SRC_DIV93, 2'b00));
        wr(REG_STAT, 32'h1);
        pins(32'hD);
        wr(REG_TXD, 32'h43);
        wr(REG_STAT, 32'h3);
        fork
            peer.sync_listen(d, per);
            wait_done;
        join
        cmp({24'h0, d}, 32'h43);
        cmp(per, 32'(DIV_93) << 4);
        repeat (100) @(posedge clk);
        cmp({31'h0, serial_data_out}, 32'h0);
        chk(REG_STAT, 32'h2, 32'h0);
        wr(REG_STAT, 32'h0);
    endtask

    task automatic t_sync_slave;
        wr(REG_CTRL, ctl(MODE_SYNC_SLAVE, SRC_DIV372, 2'b00));
        wr(REG_STAT, 32'h4);
        pins(32'hB);
        wr(REG_STAT, 32'hC);
        pins(32'hA);
        peer.sync_drive(8'h96, 20);
        pins(32'hB);
        chk(REG_RXD, 32'hFF, 32'h96);
        wr(REG_STAT, 32'h0);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        arst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tmr_uf = 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_async_tx;
        t_duplex;
        t_sync_master;
        t_sync_slave;
        complete_run;
    end
endmodule
